// file: common/ptp_port2_consts.vh
// Constants for the port 2 PTP timestamp configuration block.
// Assumes inclusion by bare name from the rtl files.
`ifndef PTP_PORT2_CONSTS_VH
`define PTP_PORT2_CONSTS_VH

// Register byte addresses
`define ADDR_AUX_ADDRESS_HIGH 12'h18c
`define ADDR_AUX_ADDRESS_LOW 12'h190
`define ADDR_TIMESTAMP_PORT_CONFIG 12'h194
`define ADDR_CAPTURE_STATUS 12'h198

// Configuration field positions
`define BIT_P2_MASTER_SELECT 31
`define BIT_P2_PRIMARY_ADDR_ENABLE 30
`define BIT_P2_ALT_ONE_ENABLE 29
`define BIT_P2_ALT_TWO_ENABLE 28
`define BIT_P2_ALT_THREE_ENABLE 27
`define BIT_P2_USER_ADDR_ENABLE 26
`define BIT_P2_LOCK_RX 25
`define BIT_P2_LOCK_TX 24
`define CFG_P2_MSB 31
`define CFG_P2_LSB 24

// Reset values
`define RST_CFG_P2 8'h43
`define RST_WORD 32'h00000000
`define RST_ADDR 12'h000
`define RST_CLOCK 64'h0000000000000000
`define RST_IDENTITY 80'h0
`define RST_SEQ 16'h0000
`define RST_AUX_HIGH 16'h0000
`define RST_AUX_LOW 32'h00000000

// Fixed PTP multicast destinations
`define PTP_ADDR_PRIMARY 48'h01005e000181
`define PTP_ADDR_ALT_ONE 48'h01005e000182
`define PTP_ADDR_ALT_TWO 48'h01005e000183
`define PTP_ADDR_ALT_THREE 48'h01005e000184

// Status register fields
`define BIT_STAT_RX_PENDING 0
`define BIT_STAT_TX_PENDING 1

// PTP message types
`define MSG_SYNC 4'h0
`define MSG_DELAY_REQ 4'h1

// AHB encodings
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010

`endif

// file: rtl/ptp_addr_match.v
// Destination address match against the five PTP addresses.
// Assumes dest and the enables are steady on the hclk domain.
`default_nettype none
`include "ptp_port2_consts.vh"

module ptp_addr_match (
   input wire [47:0] dest,
   input wire [47:0] aux_address,
   input wire [4:0] enables,
   output wire hit
);

   wire [47:0] table_addr [0:4];
   wire [4:0] per_entry;

   assign table_addr[0] = `PTP_ADDR_PRIMARY;
   assign table_addr[1] = `PTP_ADDR_ALT_ONE;
   assign table_addr[2] = `PTP_ADDR_ALT_TWO;
   assign table_addr[3] = `PTP_ADDR_ALT_THREE;
   assign table_addr[4] = aux_address;

   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_entry
         // R12: disabled entries ignored
         assign per_entry[i] = enables[i] & (dest == table_addr[i]);
      end
   endgenerate

   // R12: any enabled match
   assign hit = |per_entry;

endmodule // ptp_addr_match
`default_nettype wire

// file: rtl/ptp_port2_timestamp_config.v
// Port 2 PTP timestamp configuration and capture control with AHB-Lite registers.
// Assumes the port 2 MAC paths give one-cycle frame pulses on hclk with a parsed
// destination and message type; the clock value arrives on the same clock.
//
// Contract
// R1: Master: capture on transmitted Sync and on received Delay_Req.
// R2: Slave: capture on transmitted Delay_Req and on received Sync.
// R3: Primary enable resets to one; gates 01:00:5E:00:01:81 recognition.
// R4: Alternate one enable resets to zero; gates 01:00:5E:00:01:82.
// R5: Alternate two enable resets to zero; gates 01:00:5E:00:01:83.
// R6: Alternate three enable resets to zero; gates 01:00:5E:00:01:84.
// R7: User enable resets to zero; gates the auxiliary address.
// R8: Auxiliary address is 48 bits: 16-bit high and 32-bit low registers.
// R9: Receive lock resets to one; blocks overwrite while receive capture pending.
// R10: Transmit lock resets to one; blocks overwrite while transmit capture pending.
// R11: With a lock clear, every capture replaces the stored values.
// R12: A frame qualifies when its destination matches any enabled address.
`default_nettype none
`include "ptp_port2_consts.vh"

module ptp_port2_timestamp_config (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire tx_frame,
   input wire rx_frame,
   input wire [47:0] tx_dest,
   input wire [47:0] rx_dest,
   input wire [3:0] tx_msg_type,
   input wire [3:0] rx_msg_type,
   input wire [79:0] tx_source_identity_field,
   input wire [79:0] rx_source_identity_field,
   input wire [15:0] tx_sequence_id,
   input wire [15:0] rx_sequence_id,
   input wire [63:0] clock_value,
   output reg rx_capture_pending,
   output reg tx_capture_pending,
   output reg [63:0] rx_clock,
   output reg [79:0] rx_source_identity_field_q,
   output reg [15:0] rx_sequence_id_q,
   output reg [63:0] tx_clock,
   output reg [79:0] tx_source_identity_field_q,
   output reg [15:0] tx_sequence_id_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg [7:0] cfg_p2;
   reg [15:0] aux_address_high;
   reg [31:0] aux_address_low;

   wire p2_master_select;
   wire p2_primary_addr_enable;
   wire p2_alternate_addr_one_enable;
   wire p2_alternate_addr_two_enable;
   wire p2_alternate_addr_three_enable;
   wire p2_user_addr_enable;
   wire p2_lock_rx;
   wire p2_lock_tx;
   wire [47:0] aux_address;
   wire [4:0] addr_enables;

   assign p2_master_select = cfg_p2[`BIT_P2_MASTER_SELECT - `CFG_P2_LSB];
   assign p2_primary_addr_enable = cfg_p2[`BIT_P2_PRIMARY_ADDR_ENABLE - `CFG_P2_LSB];
   assign p2_alternate_addr_one_enable = cfg_p2[`BIT_P2_ALT_ONE_ENABLE - `CFG_P2_LSB];
   assign p2_alternate_addr_two_enable = cfg_p2[`BIT_P2_ALT_TWO_ENABLE - `CFG_P2_LSB];
   assign p2_alternate_addr_three_enable = cfg_p2[`BIT_P2_ALT_THREE_ENABLE - `CFG_P2_LSB];
   assign p2_user_addr_enable = cfg_p2[`BIT_P2_USER_ADDR_ENABLE - `CFG_P2_LSB];
   assign p2_lock_rx = cfg_p2[`BIT_P2_LOCK_RX - `CFG_P2_LSB];
   assign p2_lock_tx = cfg_p2[`BIT_P2_LOCK_TX - `CFG_P2_LSB];

   // R8: 48-bit auxiliary address
   assign aux_address = {aux_address_high, aux_address_low};

   // R3: primary address gate
   assign addr_enables[0] = p2_primary_addr_enable;
   // R4: alternate one gate
   assign addr_enables[1] = p2_alternate_addr_one_enable;
   // R5: alternate two gate
   assign addr_enables[2] = p2_alternate_addr_two_enable;
   // R6: alternate three gate
   assign addr_enables[3] = p2_alternate_addr_three_enable;
   // R7: user address gate
   assign addr_enables[4] = p2_user_addr_enable;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY

   reg wr_pending;
   reg [11:0] wr_addr;
   wire addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
   wire [11:0] word_addr = {haddr[11:2], 2'b00};

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire status_write;
   wire clr_rx;
   wire clr_tx;

   // Writing a one to a status bit clears that pending flag
   assign status_write = clk_en & wr_pending & (wr_addr == `ADDR_CAPTURE_STATUS);
   assign clr_rx = status_write & hwdata[`BIT_STAT_RX_PENDING];
   assign clr_tx = status_write & hwdata[`BIT_STAT_TX_PENDING];

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   reg next_wr_pending;
   reg [11:0] next_wr_addr;
   reg [31:0] next_hrdata;
   reg [31:0] read_word;

   // Reserved and unmapped bits read as zero
   always @* begin
      read_word = `RST_WORD;
      case (word_addr)
         `ADDR_AUX_ADDRESS_HIGH: begin
            read_word = {16'h0000, aux_address_high};
         end
         `ADDR_AUX_ADDRESS_LOW: begin
            read_word = aux_address_low;
         end
         `ADDR_TIMESTAMP_PORT_CONFIG: begin
            read_word = {cfg_p2, 24'h000000};
         end
         `ADDR_CAPTURE_STATUS: begin
            read_word = {30'h00000000, tx_capture_pending, rx_capture_pending};
         end
         default: begin
            read_word = `RST_WORD;
         end
      endcase
   end

   // The address is kept for the data phase, where hwdata stands
   always @* begin
      next_wr_pending = addr_phase & hwrite;
      next_wr_addr = wr_addr;
      next_hrdata = hrdata;
      if (addr_phase) begin
         next_wr_addr = word_addr;
      end
      if (addr_phase & ~hwrite) begin
         next_hrdata = read_word;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_addr <= `RST_ADDR;
         hrdata <= `RST_WORD;
      end else if (clk_en) begin
         wr_pending <= next_wr_pending;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   reg [7:0] next_cfg_p2;
   reg [15:0] next_aux_address_high;
   reg [31:0] next_aux_address_low;

   // Unmapped writes fall through the default and change nothing
   always @* begin
      next_cfg_p2 = cfg_p2;
      next_aux_address_high = aux_address_high;
      next_aux_address_low = aux_address_low;
      if (wr_pending) begin
         case (wr_addr)
            `ADDR_AUX_ADDRESS_HIGH: begin
               next_aux_address_high = hwdata[15:0];
            end
            `ADDR_AUX_ADDRESS_LOW: begin
               next_aux_address_low = hwdata;
            end
            `ADDR_TIMESTAMP_PORT_CONFIG: begin
               next_cfg_p2 = hwdata[`CFG_P2_MSB:`CFG_P2_LSB];
            end
            default: begin
               next_cfg_p2 = cfg_p2;
            end
         endcase
      end
   end

   // R3: primary on, others off at reset
   // R9: receive lock set at reset
   // R10: transmit lock set at reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_p2 <= `RST_CFG_P2;
         aux_address_high <= `RST_AUX_HIGH;
         aux_address_low <= `RST_AUX_LOW;
      end else if (clk_en) begin
         cfg_p2 <= next_cfg_p2;
         aux_address_high <= next_aux_address_high;
         aux_address_low <= next_aux_address_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Destination match

   wire tx_hit;
   wire rx_hit;

   ptp_addr_match u_tx_match (
      .dest(tx_dest),
      .aux_address(aux_address),
      .enables(addr_enables),
      .hit(tx_hit)
   );

   ptp_addr_match u_rx_match (
      .dest(rx_dest),
      .aux_address(aux_address),
      .enables(addr_enables),
      .hit(rx_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Capture selection

   reg [3:0] tx_want;
   reg [3:0] rx_want;
   wire tx_type_ok;
   wire rx_type_ok;
   wire tx_event;
   wire rx_event;
   wire rx_store;
   wire tx_store;
   reg next_rx_capture_pending;
   reg next_tx_capture_pending;

   // R1: master picks Sync out and Delay_Req in
   // R2: slave picks Delay_Req out and Sync in
   always @* begin
      if (p2_master_select) begin
         tx_want = `MSG_SYNC;
         rx_want = `MSG_DELAY_REQ;
      end else begin
         tx_want = `MSG_DELAY_REQ;
         rx_want = `MSG_SYNC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture events

   assign tx_type_ok = (tx_msg_type == tx_want);
   assign rx_type_ok = (rx_msg_type == rx_want);
   assign tx_event = tx_frame & tx_hit & tx_type_ok;
   assign rx_event = rx_frame & rx_hit & rx_type_ok;

   // R9: receive lock holds the first capture
   // R11: lock clear lets every capture through
   assign rx_store = rx_event & ~(p2_lock_rx & rx_capture_pending);
   // R10: transmit lock holds the first capture
   assign tx_store = tx_event & ~(p2_lock_tx & tx_capture_pending);

   ////////////////////////////////////////////////////////////////////////////
   // Capture flags

   // A capture in the clearing cycle wins the flag, but with the lock set its values are not stored
   always @* begin
      next_rx_capture_pending = rx_capture_pending;
      if (clr_rx) begin
         next_rx_capture_pending = 1'b0;
      end
      if (rx_event) begin
         next_rx_capture_pending = 1'b1;
      end
   end

   always @* begin
      next_tx_capture_pending = tx_capture_pending;
      if (clr_tx) begin
         next_tx_capture_pending = 1'b0;
      end
      if (tx_event) begin
         next_tx_capture_pending = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_capture_pending <= 1'b0;
         tx_capture_pending <= 1'b0;
      end else if (clk_en) begin
         rx_capture_pending <= next_rx_capture_pending;
         tx_capture_pending <= next_tx_capture_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stored capture values

   // R9: receive values held while locked
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_clock <= `RST_CLOCK;
         rx_source_identity_field_q <= `RST_IDENTITY;
         rx_sequence_id_q <= `RST_SEQ;
      end else if (clk_en & rx_store) begin
         rx_clock <= clock_value;
         rx_source_identity_field_q <= rx_source_identity_field;
         rx_sequence_id_q <= rx_sequence_id;
      end
   end

   // R10: transmit values held while locked
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_clock <= `RST_CLOCK;
         tx_source_identity_field_q <= `RST_IDENTITY;
         tx_sequence_id_q <= `RST_SEQ;
      end else if (clk_en & tx_store) begin
         tx_clock <= clock_value;
         tx_source_identity_field_q <= tx_source_identity_field;
         tx_sequence_id_q <= tx_sequence_id;
      end
   end

endmodule // ptp_port2_timestamp_config
`default_nettype wire

// file: tb/ptp_cfg_assertions.sv
// Checker for the port 2 PTP configuration block.
// Assumes hsel high and hready tied to hreadyout.
`default_nettype none
`include "ptp_port2_consts.vh"
module ptp_cfg_chk (
   input wire logic hclk, hresetn, clk_en, hwrite, rx_frame, tx_frame, rx_capture_pending, tx_capture_pending,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic [31:0] hwdata,
   input wire logic [47:0] rx_dest, tx_dest,
   input wire logic [3:0] rx_msg_type, tx_msg_type,
   input wire logic [63:0] clock_value, rx_clock, tx_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wp;
   logic [7:0] cfg;
   wire logic rf = clk_en && rx_frame;
   wire logic tf = clk_en && tx_frame;
   wire logic rw = rx_msg_type == {3'h0, cfg[7]};
   wire logic tw = tx_msg_type == {3'h0, !cfg[7]};
   wire logic rp = rx_dest == `PTP_ADDR_PRIMARY;
   wire logic tp = tx_dest == `PTP_ADDR_PRIMARY;
   // Shadow of the port 2 field; it lands with the write data phase
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) begin
         wp <= 1'b0;
         cfg <= `RST_CFG_P2;
      end else if (clk_en) begin
         wp <= hwrite && htrans == `HTRANS_NONSEQ && haddr[11:2] == 10'h065;
         if (wp)
            cfg <= hwdata[31:24];
      end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_rtake; rf && rw && rp && cfg[6] && !(cfg[1] && rx_capture_pending)
      |=> rx_capture_pending && rx_clock == $past(clock_value); endproperty
   a_rtake: assert property (p_rtake) else $error("rx capture missed");
   property p_ttake; tf && tw && tp && cfg[6] && !(cfg[0] && tx_capture_pending)
      |=> tx_capture_pending && tx_clock == $past(clock_value); endproperty
   a_ttake: assert property (p_ttake) else $error("tx capture missed");
   property p_rskip; rf && !rw |=> $stable(rx_clock); endproperty
   a_rskip: assert property (p_rskip) else $error("rx wrong type taken");
   property p_tskip; tf && !tw |=> $stable(tx_clock); endproperty
   a_tskip: assert property (p_tskip) else $error("tx wrong type taken");
   property p_rlock; rf && cfg[1] && rx_capture_pending |=> $stable(rx_clock); endproperty
   a_rlock: assert property (p_rlock) else $error("rx lock overwritten");
   property p_tlock; tf && cfg[0] && tx_capture_pending |=> $stable(tx_clock); endproperty
   a_tlock: assert property (p_tlock) else $error("tx lock overwritten");
   property p_rnopri; rf && rp && !cfg[6] |=> $stable(rx_clock); endproperty
   a_rnopri: assert property (p_rnopri) else $error("rx disabled address taken");
   property p_tnopri; tf && tp && !cfg[6] |=> $stable(tx_clock); endproperty
   a_tnopri: assert property (p_tnopri) else $error("tx disabled address taken");
   cover property (rf && rw && rp && cfg[6]);
   cover property (tf && cfg[0] && tx_capture_pending);
   cover property (wp);
endmodule // ptp_cfg_chk
bind ptp_port2_timestamp_config ptp_cfg_chk chk_u (.*);
`default_nettype wire

// file: tb/mac_model.sv
// Port 2 MAC model: one-cycle frame pulses and a running clock value.
// Assumes one frame at a time from the bench.
`default_nettype none
module mac_model (
   input wire logic hclk,
   output logic tx_frame = 1'b0, rx_frame = 1'b0,
   output logic [47:0] tx_dest = 48'h0, rx_dest = 48'h0,
   output logic [3:0] tx_msg_type = 4'h0, rx_msg_type = 4'h0,
   output logic [63:0] clock_value = 64'h100,
   output wire logic [79:0] tx_source_identity_field, rx_source_identity_field,
   output wire logic [15:0] tx_sequence_id, rx_sequence_id
);
   timeunit 1ns;
   timeprecision 1ps;
   // Qualifiers move every cycle, so stale values never pass for valid ones
   assign {tx_source_identity_field, rx_source_identity_field} = {16'h0, clock_value, 16'h0, ~clock_value};
   assign {tx_sequence_id, rx_sequence_id} = {clock_value[15:0], ~clock_value[15:0]};
   always @(posedge hclk)
      clock_value <= clock_value + 64'h1;
   task automatic send(input logic r, input logic [47:0] d, input logic [3:0] t);
      @(posedge hclk);
      {rx_frame, tx_frame, rx_dest, tx_dest, rx_msg_type, tx_msg_type} <= {r, !r, d, d, t, t};
      @(posedge hclk);
      {rx_frame, tx_frame, rx_dest, tx_dest, rx_msg_type, tx_msg_type} <= {2'b00, ~d, ~d, ~t, ~t};
   endtask
endmodule // mac_model
`default_nettype wire

// file: tb/tb_top.sv
// Bench: AHB-Lite register access and port 2 captures through the MAC model.
// Assumes the checker binds itself to the design.
`default_nettype none
`include "ptp_port2_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b1, hwrite = 1'b0;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic [31:0] hwdata = 32'h0, rd;
   logic [63:0] ex [2] = '{64'h0, 64'h0};
   logic [47:0] at [5] = '{`PTP_ADDR_PRIMARY, `PTP_ADDR_ALT_ONE, `PTP_ADDR_ALT_TWO, `PTP_ADDR_ALT_THREE, 48'ha0b0c0d0e0f};
   int failures = 0, tests_run = 0;
   wire logic hready, hreadyout, hresp, tx_frame, rx_frame, rx_capture_pending, tx_capture_pending;
   wire logic [31:0] hrdata;
   wire logic [47:0] tx_dest, rx_dest;
   wire logic [3:0] tx_msg_type, rx_msg_type;
   wire logic [79:0] tx_source_identity_field, rx_source_identity_field;
   wire logic [79:0] tx_source_identity_field_q, rx_source_identity_field_q;
   wire logic [15:0] tx_sequence_id, rx_sequence_id, rx_sequence_id_q, tx_sequence_id_q;
   wire logic [63:0] clock_value, rx_clock, tx_clock;
   assign hready = hreadyout;
   ptp_port2_timestamp_config dut_u (.*);
   mac_model mac_u (.*);
   always #12.5 hclk = ~hclk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge hclk);
      {haddr, hwrite, htrans} <= {a, wr, `HTRANS_NONSEQ};
      do @(posedge hclk); while (hready !== 1'b1);
      {htrans, hwdata} <= {2'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic fr(input logic r, input logic [47:0] d, input logic [3:0] t, input logic hit);
      mac_u.send(r, d, t);
      #1;
      if (hit)
         ex[r] = clock_value - 64'h1;
      chk(r ? rx_clock : tx_clock, ex[r]);
      chk(r ? rx_sequence_id_q : tx_sequence_id_q, ex[r][15:0] ^ {16{r}});
      chk(r ? rx_source_identity_field_q[63:0] : tx_source_identity_field_q[63:0], ex[r] ^ {64{r}});
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      failures++;
      close_out;
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 12'h194, 32'h0);
      chk(rd, 64'h43000000);
      chk({hreadyout, hresp}, 64'h2);
      bus(1'b1, 12'h18c, 32'hffff0a0b);
      bus(1'b1, 12'h190, 32'h0c0d0e0f);
      bus(1'b0, 12'h18c, 32'h0);
      chk(rd, 64'h0a0b);
      bus(1'b0, 12'h1a0, 32'h0);
      chk(rd, 64'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 12'h194, {1'b1, 5'h10 >> i, 26'h0});
         fr(1'b1, at[i], `MSG_DELAY_REQ, 1'b1);
         bus(1'b1, 12'h194, {1'b1, ~(5'h10 >> i), 26'h0});
         fr(1'b1, at[i], `MSG_DELAY_REQ, 1'b0);
         fr(1'b0, at[i], `MSG_SYNC, 1'b0);
      end
      fr(1'b1, 48'h01005e000185, `MSG_DELAY_REQ, 1'b0);
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, 12'h194, {m[0], 31'h40000000});
         for (int k = 0; k < 4; k++)
            fr(k[1], `PTP_ADDR_PRIMARY, {3'h0, k[0]}, (k[1] ^ k[0]) != m[0]);
      end
      bus(1'b1, 12'h194, 32'hc3000000);
      bus(1'b1, 12'h198, 32'h3);
      for (int r = 0; r < 2; r++) begin
         fr(r[0], `PTP_ADDR_PRIMARY, {3'h0, r[0]}, 1'b1);
         fr(r[0], `PTP_ADDR_PRIMARY, {3'h0, r[0]}, 1'b0);
         chk(r[0] ? rx_capture_pending : tx_capture_pending, 64'h1);
      end
      bus(1'b1, 12'h194, 32'hc0000000);
      for (int r = 0; r < 2; r++)
         fr(r[0], `PTP_ADDR_PRIMARY, {3'h0, r[0]}, 1'b1);
      @(posedge hclk);
      clk_en <= 1'b0;
      fr(1'b1, `PTP_ADDR_PRIMARY, `MSG_DELAY_REQ, 1'b0);
      close_out;
   end
endmodule // tb_top
`default_nettype wire
